//--- logic/wtcm_monitor.sv
// Chosen here: strobed register access and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module wtcm_monitor
#(
  parameter int unsigned CM_TIMEOUT = wtcm_pkg::CM_TIMEOUT_CYC
)
(
  input  wire logic                  mclk,
  input  wire logic                  rst,
  input  wire wtcm_pkg::wtcm_bus_req_t bus_req,
  output var  logic [wtcm_pkg::DATA_W-1:0] rd_data,
  input  wire logic                  low_power,
  input  wire logic                  osc_clock_input,
  input  wire logic                  port_g_pin1_in,
  output var  logic                  timeout_fault_out,
  output var  logic                  timeout_fault_oe_n
);
  import wtcm_pkg::*;

  logic [DIV_W-1:0]  div_q;
  logic              instr_en;
  logic [1:0]        pin_sync_q;
  logic [2:0]        osc_sync_q;
  logic              pin_low;
  logic              osc_edge;
  logic [DATA_W-1:0] cfg_q;
  logic              mon_en;
  logic [1:0]        win_q;
  logic              cm_en_q;
  logic              first_done_q;
  logic [CNT_W-1:0]  cnt_q;
  logic [CNT_W-1:0]  upper_lim;
  logic              svc_wr;
  logic              key_ok;
  logic              fields_ok;
  logic              busy;
  logic              svc_take;
  logic              svc_ok;
  logic              svc_err;
  logic              timeout;
  wtcm_tstate_t      tstate_q;
  logic [HOLD_W-1:0] hold_q;
  logic [CM_W-1:0]   cm_cnt_q;
  logic              cm_err_q;
  logic [HOLD_W-1:0] cm_hold_q;
  logic              drive_q;
  logic              fault_d;

  // Instruction-cycle enable from the system clock divider.
  always_ff @(posedge mclk)
  begin
    if (rst || div_q == DIV_W'(INSTR_DIV - 1))
      div_q <= '0;
    else
      div_q <= div_q + 1'b1;
  end
  assign instr_en = (div_q == DIV_W'(INSTR_DIV - 1));

  // Pin and oscillator levels come from outside, so each passes two flops first.
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      pin_sync_q <= 2'h3;
      osc_sync_q <= 3'h0;
    end
    else
    begin
      pin_sync_q <= {pin_sync_q[0], port_g_pin1_in};
      osc_sync_q <= {osc_sync_q[1:0], osc_clock_input};
    end
  end
  assign pin_low  = ~pin_sync_q[1];
  assign osc_edge = osc_sync_q[2] ^ osc_sync_q[1];

  // Configuration option register; the disable bit switches the whole monitor off.
  always_ff @(posedge mclk)
  begin
    if (rst)
      cfg_q <= CFG_RESET;
    else if (bus_req.wr && bus_req.addr == ADDR_CONFIG)
      cfg_q <= bus_req.wdata;
  end
  assign mon_en = ~cfg_q[CFG_DIS_BIT];

  // Service decode. The window, key and monitor bit are compared over bits 7..0 after the first write.
  assign svc_wr    = mon_en && bus_req.wr && bus_req.addr == ADDR_SVC;
  assign key_ok    = bus_req.wdata[KEY_MSB:KEY_LSB] == KEY_VALUE;
  assign fields_ok = key_ok && bus_req.wdata[WIN_MSB:WIN_LSB] == win_q
                     && bus_req.wdata[CM_BIT] == cm_en_q;
  assign busy      = (tstate_q != T_IDLE) || pin_low;
  assign svc_take  = svc_wr && !busy;
  assign svc_ok    = svc_take && (first_done_q
                     ? (fields_ok && cnt_q >= CNT_W'(LOWER_LIMIT)) : key_ok);
  assign svc_err   = svc_take && !svc_ok;
  assign upper_lim = CNT_W'(UPPER_BASE) << win_q;
  assign timeout   = tstate_q == T_IDLE && instr_en && !low_power
                     && cnt_q == upper_lim - 1'b1;

  // Window and monitor choice: armed at reset, fixed by the first keyed write only.
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      win_q        <= WIN_RESET;
      cm_en_q      <= CM_RESET;
      first_done_q <= 1'b0;
    end
    else if (svc_ok && !first_done_q)
    begin
      win_q        <= bus_req.wdata[WIN_MSB:WIN_LSB];
      cm_en_q      <= bus_req.wdata[CM_BIT];
      first_done_q <= 1'b1;
    end
  end

  // Window counter, in instruction cycles. It stands still in low-power modes, so a
  // stopped core is not punished, and restarts on each valid service or timeout fault release.
  always_ff @(posedge mclk)
  begin
    if (rst || !mon_en || tstate_q != T_IDLE || svc_ok)
      cnt_q <= '0;
    else if (instr_en && !low_power)
      cnt_q <= cnt_q + 1'b1;
  end

  // Timeout fault sequence: drive low, wait to see the pin low, hold, release.
  always_ff @(posedge mclk)
  begin
    if (rst || !mon_en)
    begin
      tstate_q <= T_IDLE;
      hold_q   <= '0;
    end
    else
    begin
      unique case (tstate_q)
        T_IDLE:
          if (svc_err || timeout)
            tstate_q <= T_DRIVE;
        T_DRIVE:
          if (pin_low)
          begin
            tstate_q <= T_HOLD;
            hold_q   <= HOLD_W'(FAULT_HOLD_CYC - 1);
          end
        T_HOLD:
          if (instr_en)
          begin
            if (hold_q == '0)
              tstate_q <= T_WAIT;
            else
              hold_q <= hold_q - 1'b1;
          end
        T_WAIT:
          if (!pin_low)
            tstate_q <= T_IDLE;
      endcase
    end
  end

  // Clock monitor: a missing oscillator edge for the timeout span is a frequency error.
  // The span sits between 100 us (10 kHz cycle rate) and 100 ms (10 Hz), so both
  // limits hold with margin; the monitor keeps running in halt and idle.
  always_ff @(posedge mclk)
  begin
    if (rst || !mon_en || !cm_en_q || osc_edge)
      cm_cnt_q <= '0;
    else if (cm_cnt_q != CM_W'(CM_TIMEOUT))
      cm_cnt_q <= cm_cnt_q + 1'b1;
  end

  // Error level and its release hold after the clock recovers.
  always_ff @(posedge mclk)
  begin
    if (rst || !mon_en || !cm_en_q)
    begin
      cm_err_q  <= 1'b0;
      cm_hold_q <= '0;
    end
    else if (cm_cnt_q == CM_W'(CM_TIMEOUT))
    begin
      cm_err_q  <= 1'b1;
      cm_hold_q <= HOLD_W'(FAULT_HOLD_CYC);
    end
    else
    begin
      cm_err_q <= 1'b0;
      if (instr_en && cm_hold_q != '0)
        cm_hold_q <= cm_hold_q - 1'b1;
    end
  end

  // Either source pulls the shared open-drain pin low.
  assign fault_d = mon_en && (tstate_q == T_DRIVE || tstate_q == T_HOLD
                   || cm_err_q || cm_hold_q != '0);

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      drive_q            <= 1'b0;
      timeout_fault_out  <= 1'b0;
      timeout_fault_oe_n <= 1'b1;
    end
    else
    begin
      drive_q            <= fault_d;
      timeout_fault_out  <= 1'b0;
      timeout_fault_oe_n <= ~fault_d;
    end
  end

  // Register reads, answered the cycle after the strobe; the key never reads back.
  always_ff @(posedge mclk)
  begin
    if (rst)
      rd_data <= '0;
    else if (bus_req.rd)
    begin
      unique case (bus_req.addr)
        ADDR_SVC:    rd_data <= {win_q, KEY_READ, cm_en_q};
        ADDR_STATUS: rd_data <= {3'h0, first_done_q, cm_err_q, drive_q, pin_low,
                                 (tstate_q != T_IDLE)};
        ADDR_CONFIG: rd_data <= cfg_q;
        default:     rd_data <= '0;
      endcase
    end
    else
      rd_data <= '0;
  end

  // Checks on the monitor's own behaviour.
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  // Checked one edge after reset is sampled, so the very first edge never sees stale values.
  a_reset_armed: assert property (@(posedge mclk) disable iff (1'b0)
    rst |=> win_q == WIN_RESET && cm_en_q && !first_done_q)
    else $error("Monitor not armed after reset.");

  a_key_read_zero: assert property (bus_req.rd && bus_req.addr == ADDR_SVC
    |=> rd_data[KEY_MSB:KEY_LSB] == KEY_READ)
    else $error("Key field read back nonzero.");

  a_bad_key_fault: assert property (svc_take && !key_ok
    |=> tstate_q == T_DRIVE ##1 !timeout_fault_oe_n)
    else $error("Bad key did not raise fault.");

  a_early_fault: assert property (svc_take && first_done_q && key_ok
    && cnt_q < CNT_W'(LOWER_LIMIT) |=> tstate_q == T_DRIVE)
    else $error("Early service not flagged.");

  a_upper_expire: assert property (tstate_q == T_IDLE && mon_en && instr_en
    && !low_power && cnt_q == upper_lim - 1'b1 |=> tstate_q == T_DRIVE)
    else $error("Upper limit expiry missed.");

  a_first_locks: assert property (svc_ok && !first_done_q
    |=> win_q == $past(bus_req.wdata[WIN_MSB:WIN_LSB]) && first_done_q)
    else $error("First service did not fix window.");

  a_later_frozen: assert property (first_done_q |=> $stable(win_q)
    && $stable(cm_en_q))
    else $error("Window changed after first service.");

  a_busy_ignored: assert property (svc_wr && busy |-> !svc_ok && !svc_err)
    else $error("Service taken during fault.");

  a_cm_drives: assert property (cm_err_q && mon_en |=> !timeout_fault_oe_n)
    else $error("Clock error did not drive pin.");

  a_disabled_quiet: assert property (!mon_en |=> timeout_fault_oe_n)
    else $error("Disabled monitor drove pin.");

  a_paused_count: assert property (low_power && tstate_q == T_IDLE && !svc_ok
    |=> $stable(cnt_q))
    else $error("Window counted in low power.");

  c_valid_service: cover property (svc_ok && first_done_q);
  c_timeout: cover property (timeout);
  c_clock_error: cover property (cm_err_q);
  c_release: cover property (tstate_q == T_WAIT ##1 tstate_q == T_IDLE);

endmodule
`default_nettype wire

//--- logic/wtcm_pkg.sv
`default_nettype none
// Shared constants and carriers of the windowed timeout and clock monitor.
package wtcm_pkg;

  // Register bus widths and register offsets.
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;
  localparam logic [ADDR_W-1:0] ADDR_SVC    = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h01;
  localparam logic [ADDR_W-1:0] ADDR_CONFIG = 8'h02;

  // Service register field layout and fixed key.
  localparam int unsigned WIN_MSB = 7;
  localparam int unsigned WIN_LSB = 6;
  localparam int unsigned KEY_MSB = 5;
  localparam int unsigned KEY_LSB = 1;
  localparam int unsigned CM_BIT  = 0;
  localparam logic [4:0]  KEY_VALUE = 5'h0C;
  localparam logic [4:0]  KEY_READ  = 5'h00;
  localparam logic [1:0]  WIN_RESET = 2'h3;
  localparam logic        CM_RESET  = 1'b1;

  // Configuration option register: bit set means monitor disabled.
  localparam int unsigned CFG_DIS_BIT = 2;
  localparam logic [DATA_W-1:0] CFG_RESET = 8'h00;

  // Timing: system clock and instruction cycle.
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned T_INSTR_NS    = 1000;
  localparam int unsigned INSTR_DIV     = T_INSTR_NS / CLK_PERIOD_NS;
  localparam int unsigned DIV_W         = 7;

  // Service window limits in instruction cycles.
  localparam int unsigned CNT_W          = 17;
  localparam int unsigned LOWER_LIMIT    = 256;
  localparam int unsigned UPPER_BASE     = 8192;

  // Fault hold after the pin is seen low, in instruction cycles (16 to 32).
  localparam int unsigned FAULT_HOLD_CYC = 24;
  localparam int unsigned HOLD_W         = 5;

  // Clock monitor: oscillator edge must arrive within this time.
  localparam int unsigned CM_TIMEOUT_US  = 1000;
  localparam int unsigned CM_TIMEOUT_CYC = CM_TIMEOUT_US * 1000 / CLK_PERIOD_NS;
  localparam int unsigned CM_W           = 20;

  // Register bus request carrier.
  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } wtcm_bus_req_t;

  // Timeout fault sequence states, one-hot.
  typedef enum logic [3:0] {
    T_IDLE  = 4'h1,
    T_DRIVE = 4'h2,
    T_HOLD  = 4'h4,
    T_WAIT  = 4'h8
  } wtcm_tstate_t;

endpackage
`default_nettype wire

//--- verif/windowed_timeout_clock_monitor_bench.sv
`timescale 1ns/10ps
`default_nettype none
// Register-level regression of the windowed timeout and clock monitor.
module windowed_timeout_clock_monitor_bench;
  import wtcm_pkg::*;
  logic          mclk = 1'b0;
  logic          rst = 1'b1;
  logic          low_power = 1'b0;
  logic          osc_run = 1'b1;
  wtcm_bus_req_t bus_req = '0;
  logic [7:0]    rd_data;
  logic          oe_n;
  logic          pin;
  logic          osc;
  logic [7:0]    d;
  int            n;
  int            err_count = 0;
  int            comparisons = 0;

  // Clock at 100 MHz.
  always #5 mclk = ~mclk;

  // A short clock-monitor timeout keeps the run brief.
  wtcm_monitor #(.CM_TIMEOUT(200)) i_wtcm_monitor
  (
    .mclk               (mclk),
    .rst                (rst),
    .bus_req            (bus_req),
    .rd_data            (rd_data),
    .low_power          (low_power),
    .osc_clock_input    (osc),
    .port_g_pin1_in     (pin),
    .timeout_fault_out  (),
    .timeout_fault_oe_n (oe_n)
  );

  wtcm_pin_model i_wtcm_pin_model
  (
    .mclk    (mclk),
    .oe_n    (oe_n),
    .osc_run (osc_run),
    .pin     (pin),
    .osc     (osc)
  );

  // Compare tasks count every check and report mismatches at once.
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      err_count++;
      $display("ERROR %0t: data %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic chkb(input logic got, input logic exp);
    comparisons++;
    if (got !== exp)
    begin
      err_count++;
      $display("ERROR %0t: flag %b, expected %b", $time, got, exp);
    end
  endtask

  // Bus cycles: one-cycle strobes launched just after a rising edge.
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge mclk);
    bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
    @(posedge mclk);
    bus_req <= '0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge mclk);
    bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge mclk);
    bus_req <= '0;
    #1 v = rd_data;
  endtask

  // Bounded wait for the pin enable to reach a level; n holds the cycles.
  task automatic wait_oe(input logic lvl, input int lim);
    n = 0;
    while (oe_n !== lvl && n < lim)
    begin
      @(posedge mclk);
      n++;
    end
  endtask

  task automatic results;
    $display("Comparisons %0d, mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // A hang is cut short a little after the roughly 90k cycles the tests need.
  initial
  begin
    #1_000_000;
    err_count++;
    results();
  end

  // Main sequence.
  initial
  begin
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    rd(ADDR_SVC, d);
    chk8(d, 8'hC1);
    chkb(oe_n, 1'b1);
    rd(ADDR_CONFIG, d);
    chk8(d, 8'h00);
    rd(8'h07, d);
    chk8(d, 8'h00);
    $display("Test reset done");
    wr(ADDR_CONFIG, 8'h04);
    wr(ADDR_SVC, 8'h00);
    wait_oe(1'b0, 50);
    chkb(oe_n, 1'b1);
    wr(ADDR_CONFIG, 8'h00);
    $display("Test disable done");
    wr(ADDR_SVC, 8'h19);
    rd(ADDR_SVC, d);
    chk8(d, 8'h01);
    wr(ADDR_SVC, 8'h19);
    wait_oe(1'b0, 10);
    chkb(oe_n, 1'b0);
    wait_oe(1'b1, 4000);
    chkb(n >= 1600 && n <= 3300, 1'b1);
    $display("Test early service done");
    repeat (26000) @(posedge mclk);
    wr(ADDR_SVC, 8'h19);
    wait_oe(1'b0, 50);
    chkb(oe_n, 1'b1);
    repeat (26000) @(posedge mclk);
    wr(ADDR_SVC, 8'hD9);
    wait_oe(1'b0, 10);
    chkb(oe_n, 1'b0);
    rd(ADDR_SVC, d);
    chk8(d, 8'h01);
    wait_oe(1'b1, 4000);
    chkb(oe_n, 1'b1);
    $display("Test window service done");
    osc_run <= 1'b0;
    wait_oe(1'b0, 400);
    chkb(oe_n, 1'b0);
    osc_run <= 1'b1;
    wait_oe(1'b1, 4000);
    chkb(n >= 1600 && n <= 3300, 1'b1);
    $display("Test clock monitor done");
    // About 30 cycles counted before the pause; without it the service would be late enough.
    low_power <= 1'b1;
    repeat (26000) @(posedge mclk);
    low_power <= 1'b0;
    wr(ADDR_SVC, 8'h19);
    wait_oe(1'b0, 10);
    chkb(oe_n, 1'b0);
    wait_oe(1'b1, 4000);
    chkb(oe_n, 1'b1);
    $display("Test low power done");
    results();
  end
endmodule
`default_nettype wire

//--- verif/wtcm_pin_model.sv
`timescale 1ns/10ps
`default_nettype none
// Far side of the fault pin (pull-up plus whoever listens) and the oscillator
// that feeds the clock monitor.
module wtcm_pin_model
(
  input  wire logic mclk,
  input  wire logic oe_n,
  input  wire logic osc_run,
  output var  logic pin,
  output var  logic osc
);
  logic [4:0] div_q = 5'h00;
  logic       osc_q = 1'b0;

  // Nobody else pulls the wire low, so the weak pull-up wins whenever the
  // monitor lets go.
  always_comb
  begin
    pin = oe_n ? 1'b1 : 1'b0;
    osc = osc_q;
  end

  // The oscillator toggles every 20 clocks; it freezes dead when stopped,
  // as a failed crystal would.
  always_ff @(posedge mclk)
  begin
    if (osc_run)
    begin
      div_q <= (div_q == 5'h13) ? 5'h00 : div_q + 5'h01;
      if (div_q == 5'h13)
        osc_q <= ~osc_q;
    end
  end
endmodule
`default_nettype wire
